// >>> hw/misc_pin_config_regs.sv
// general pin configuration, status and interrupt logic
//
// Contract
// - pin 3 as output drives low for output bit 0, high for 1.
// - pin 3 becomes an input after reset and on suspend.
// - pin 4 direction bit 4 of first register: 0 input, 1 output.
// - pin 4 polarity bit 5: 0 low is asserted, 1 high is.
// - pin 4 sensing bit 6 at 0: status shows present assertion.
// - pin 4 sensing bit 6 at 1: status latches, read clears.
// - pin 4 as output drives low or high per output bit 7.
// - pin 4 defaults to output driving high after reset, suspend.
// - pin 5 direction bit 0 of second register: 0 in, 1 out.
// - pin 5 polarity bit 1: 0 low is asserted, 1 high is.
// - pin 5 sensing bit 2 at 0: status follows present assertion.
// - pin 5 sensing bit 2 at 1: status latches, read clears.
// - pin 5 output per bit 3; default output driving high.
// - pin 6 direction bit 4 of second register: 0 in, 1 out.
// - pin 6 polarity bit 5: 0 low is asserted, 1 high is.
// - pin 6 sensing bit 6 at 0: status shows present assertion.
// - pin 6 sensing bit 6 at 1: status latches until next read.
// - pin 6 output per bit 7; default output driving low.
//
// The AXI4-Lite slave port was chosen for this implementation.
`timescale 1ns/1ns
`default_nettype none

module misc_pin_config_regs #(
    parameter int PINS = misc_pin_pkg::PIN_COUNT
) (
    // clock, reset, enable
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic ce,
    // power state
    input wire logic usb_suspend,
    // axi4-lite write address
    input wire logic [misc_pin_pkg::ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    // axi4-lite write data
    input wire logic [misc_pin_pkg::DATA_W-1:0] s_axi_wdata,
    input wire logic [misc_pin_pkg::DATA_W/8-1:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // axi4-lite write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // axi4-lite read address
    input wire logic [misc_pin_pkg::ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    // axi4-lite read data
    output logic [misc_pin_pkg::DATA_W-1:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // general pins 3..6, index 0 is pin 3
    input wire logic [PINS-1:0] pin_in,
    output logic [PINS-1:0] pin_out,
    output logic [PINS-1:0] pin_oe,
    // interrupt
    output logic irq
);

    // address decode shared by read and write
    function automatic misc_pin_pkg::reg_sel_t decode(
        input logic [misc_pin_pkg::ADDR_W-1:0] addr
    );
        logic [misc_pin_pkg::ADDR_W-1:0] base;
        base = addr >> misc_pin_pkg::IDX_LSB;
        if (addr[misc_pin_pkg::IDX_LSB-1:0] != '0) begin
            return misc_pin_pkg::SEL_NONE;
        end
        case (base)
            misc_pin_pkg::ADDR_W'(misc_pin_pkg::IDX_CFG34): begin
                return misc_pin_pkg::SEL_CFG34;
            end
            misc_pin_pkg::ADDR_W'(misc_pin_pkg::IDX_CFG56): begin
                return misc_pin_pkg::SEL_CFG56;
            end
            misc_pin_pkg::ADDR_W'(misc_pin_pkg::IDX_STATUS): begin
                return misc_pin_pkg::SEL_STATUS;
            end
            misc_pin_pkg::ADDR_W'(misc_pin_pkg::IDX_IRQ_STAT): begin
                return misc_pin_pkg::SEL_IRQ_STAT;
            end
            misc_pin_pkg::ADDR_W'(misc_pin_pkg::IDX_IRQ_MASK): begin
                return misc_pin_pkg::SEL_IRQ_MASK;
            end
            default: begin
                return misc_pin_pkg::SEL_NONE;
            end
        endcase
    endfunction

    // configuration registers
    logic [misc_pin_pkg::CFG_W-1:0] cfg34_r;
    logic [misc_pin_pkg::CFG_W-1:0] cfg56_r;
    misc_pin_pkg::pin_cfg_t cfg [PINS];

    // pin state
    logic [PINS-1:0] sync1_r;
    logic [PINS-1:0] sync2_r;
    logic [PINS-1:0] asserted;
    logic [PINS-1:0] asserted_d_r;
    logic [PINS-1:0] latch_r;
    logic [PINS-1:0] latch_nxt;
    logic [PINS-1:0] status;

    // interrupt registers
    logic [PINS-1:0] irq_stat_r;
    logic [PINS-1:0] irq_mask_r;
    logic [PINS-1:0] pin_event;

    // bus state
    misc_pin_pkg::wr_hold_t wr_r;
    logic bvalid_r;
    logic [1:0] bresp_r;
    logic rvalid_r;
    logic [1:0] rresp_r;
    logic [misc_pin_pkg::DATA_W-1:0] rdata_r;
    logic aw_fire;
    logic w_fire;
    logic ar_fire;
    logic do_write;
    misc_pin_pkg::reg_sel_t wr_sel;
    misc_pin_pkg::reg_sel_t rd_sel;
    logic wr_lane0;
    logic [misc_pin_pkg::CFG_W-1:0] wr_byte;
    logic status_read;
    logic [misc_pin_pkg::DATA_W-1:0] rd_word;

    // handshakes, frozen while ce is low
    assign s_axi_awready = ce && !wr_r.addr_ok && !bvalid_r;
    assign s_axi_wready = ce && !wr_r.data_ok && !bvalid_r;
    assign s_axi_arready = ce && !rvalid_r;
    assign aw_fire = s_axi_awvalid && s_axi_awready;
    assign w_fire = s_axi_wvalid && s_axi_wready;
    assign ar_fire = s_axi_arvalid && s_axi_arready;
    assign do_write = ce && wr_r.addr_ok && wr_r.data_ok && !bvalid_r;
    assign wr_sel = decode(wr_r.addr);
    assign rd_sel = decode(s_axi_araddr);
    assign wr_lane0 = wr_r.strb[0];
    assign wr_byte = wr_r.data[misc_pin_pkg::CFG_W-1:0];
    assign status_read = ar_fire && (rd_sel == misc_pin_pkg::SEL_STATUS);

    assign s_axi_bvalid = bvalid_r;
    assign s_axi_bresp = bresp_r;
    assign s_axi_rvalid = rvalid_r;
    assign s_axi_rresp = rresp_r;
    assign s_axi_rdata = rdata_r;

    // write address and data capture, either order
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            wr_r <= '0;
        end else if (ce) begin
            if (aw_fire) begin
                wr_r.addr_ok <= 1'b1;
                wr_r.addr <= s_axi_awaddr;
            end else if (do_write) begin
                wr_r.addr_ok <= 1'b0;
            end
            if (w_fire) begin
                wr_r.data_ok <= 1'b1;
                wr_r.data <= s_axi_wdata;
                wr_r.strb <= s_axi_wstrb;
            end else if (do_write) begin
                wr_r.data_ok <= 1'b0;
            end
        end
    end

    // write response
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            bvalid_r <= 1'b0;
            bresp_r <= misc_pin_pkg::RESP_OKAY;
        end else if (ce) begin
            if (do_write) begin
                bvalid_r <= 1'b1;
                if (wr_sel == misc_pin_pkg::SEL_NONE) begin
                    bresp_r <= misc_pin_pkg::RESP_SLVERR;
                end else begin
                    bresp_r <= misc_pin_pkg::RESP_OKAY;
                end
            end else if (s_axi_bready) begin
                bvalid_r <= 1'b0;
            end
        end
    end

    // configuration registers, defaults on reset and suspend
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            cfg34_r <= misc_pin_pkg::CFG34_DEFAULT;
            cfg56_r <= misc_pin_pkg::CFG56_DEFAULT;
        end else if (ce) begin
            if (usb_suspend) begin
                cfg34_r <= misc_pin_pkg::CFG34_DEFAULT;
                cfg56_r <= misc_pin_pkg::CFG56_DEFAULT;
            end else if (do_write && wr_lane0) begin
                if (wr_sel == misc_pin_pkg::SEL_CFG34) begin
                    cfg34_r <= wr_byte;
                end
                if (wr_sel == misc_pin_pkg::SEL_CFG56) begin
                    cfg56_r <= wr_byte;
                end
            end
        end
    end

    // nibble per pin: 3 and 4 from first, 5 and 6 from second
    assign cfg[0] = misc_pin_pkg::pin_cfg_t'(cfg34_r[3:0]);
    assign cfg[1] = misc_pin_pkg::pin_cfg_t'(cfg34_r[7:4]);
    assign cfg[2] = misc_pin_pkg::pin_cfg_t'(cfg56_r[3:0]);
    assign cfg[3] = misc_pin_pkg::pin_cfg_t'(cfg56_r[7:4]);

    // input synchroniser
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            sync1_r <= '0;
            sync2_r <= '0;
            asserted_d_r <= '0;
        end else if (ce) begin
            sync1_r <= pin_in;
            sync2_r <= sync1_r;
            asserted_d_r <= asserted;
        end
    end

    // per-pin polarity, sensing and drive
    for (genvar i = 0; i < PINS; i++) begin : g_pin
        // asserted when the level matches the polarity bit
        assign asserted[i] = (sync2_r[i] == cfg[i].pol_high);

        // edge latch holds until the status is read
        always_comb begin
            latch_nxt[i] = latch_r[i];
            if (status_read) begin
                latch_nxt[i] = 1'b0;
            end
            if (asserted[i]) begin
                latch_nxt[i] = 1'b1;
            end
        end

        // level or edge view
        assign status[i] = cfg[i].edge_mode ? latch_r[i] : asserted[i];

        // drive straight from the configuration flops
        assign pin_out[i] = cfg[i].out_high;
        assign pin_oe[i] = cfg[i].is_out;

        // new assertion raises an interrupt event
        assign pin_event[i] = asserted[i] && !asserted_d_r[i];
    end

    // edge latches
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            latch_r <= '0;
        end else if (ce) begin
            latch_r <= latch_nxt;
        end
    end

    // sticky interrupt status, write one to clear, set wins
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            irq_stat_r <= '0;
        end else if (ce) begin
            if (do_write && wr_lane0 &&
                wr_sel == misc_pin_pkg::SEL_IRQ_STAT) begin
                irq_stat_r <= (irq_stat_r & ~wr_byte[PINS-1:0])
                    | pin_event;
            end else begin
                irq_stat_r <= irq_stat_r | pin_event;
            end
        end
    end

    // interrupt mask, one enables the bit
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            irq_mask_r <= '0;
        end else if (ce) begin
            if (do_write && wr_lane0 &&
                wr_sel == misc_pin_pkg::SEL_IRQ_MASK) begin
                irq_mask_r <= wr_byte[PINS-1:0];
            end
        end
    end

    assign irq = |(irq_stat_r & irq_mask_r);

    // read mux
    always_comb begin
        rd_word = '0;
        case (rd_sel)
            misc_pin_pkg::SEL_CFG34: begin
                rd_word[misc_pin_pkg::CFG_W-1:0] = cfg34_r;
            end
            misc_pin_pkg::SEL_CFG56: begin
                rd_word[misc_pin_pkg::CFG_W-1:0] = cfg56_r;
            end
            misc_pin_pkg::SEL_STATUS: begin
                rd_word[PINS-1:0] = status;
            end
            misc_pin_pkg::SEL_IRQ_STAT: begin
                rd_word[PINS-1:0] = irq_stat_r;
            end
            misc_pin_pkg::SEL_IRQ_MASK: begin
                rd_word[PINS-1:0] = irq_mask_r;
            end
            default: begin
                rd_word = '0;
            end
        endcase
    end

    // read data and response
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            rvalid_r <= 1'b0;
            rresp_r <= misc_pin_pkg::RESP_OKAY;
            rdata_r <= '0;
        end else if (ce) begin
            if (ar_fire) begin
                rvalid_r <= 1'b1;
                rdata_r <= rd_word;
                if (rd_sel == misc_pin_pkg::SEL_NONE) begin
                    rresp_r <= misc_pin_pkg::RESP_SLVERR;
                end else begin
                    rresp_r <= misc_pin_pkg::RESP_OKAY;
                end
            end else if (s_axi_rready) begin
                rvalid_r <= 1'b0;
            end
        end
    end

endmodule

`default_nettype wire

// >>> hw/misc_pin_pkg.sv
// constants and types for the general pin configuration block
package misc_pin_pkg;

    // pins handled here: general pins 3, 4, 5 and 6
    localparam int PIN_COUNT = 4;
    localparam int CFG_W = 8;
    localparam int FIELD_W = 4;
    localparam int DATA_W = 32;
    localparam int ADDR_W = 12;

    // register indices; byte address is four times the index
    localparam logic [7:0] IDX_CFG34 = 8'h5a;
    localparam logic [7:0] IDX_CFG56 = 8'h5b;
    localparam logic [7:0] IDX_STATUS = 8'h60;
    localparam logic [7:0] IDX_IRQ_STAT = 8'h61;
    localparam logic [7:0] IDX_IRQ_MASK = 8'h62;
    localparam int IDX_LSB = 2;

    // power-on and suspend defaults
    // pins 3..4: pin 3 input, pin 4 output high
    localparam logic [7:0] CFG34_DEFAULT = 8'h90;
    // pins 5..6: pin 5 output high, pin 6 output low
    localparam logic [7:0] CFG56_DEFAULT = 8'h19;

    // axi response codes
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // per-pin field, one nibble of a configuration register
    typedef struct packed {
        logic out_high;
        logic edge_mode;
        logic pol_high;
        logic is_out;
    } pin_cfg_t;

    // register selected by an address
    typedef enum logic [2:0] {
        SEL_CFG34 = 3'b000,
        SEL_CFG56 = 3'b001,
        SEL_STATUS = 3'b010,
        SEL_IRQ_STAT = 3'b011,
        SEL_IRQ_MASK = 3'b100,
        SEL_NONE = 3'b111
    } reg_sel_t;

    // pending write held until address and data are both in
    typedef struct packed {
        logic addr_ok;
        logic [ADDR_W-1:0] addr;
        logic data_ok;
        logic [DATA_W-1:0] data;
        logic [DATA_W/8-1:0] strb;
    } wr_hold_t;

endpackage

// >>> tb/misc_pin_config_regs_monitor.sv
// bus and pin checks for the general pin block
`timescale 1ns/1ns
`default_nettype none
module misc_pin_config_regs_monitor #(
    parameter int PINS = 4
) (
    // clock, reset, power
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic ce,
    input wire logic usb_suspend,
    // bus handshakes
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    input wire logic [31:0] s_axi_rdata,
    input wire logic s_axi_rready,
    // pins
    input wire logic [PINS-1:0] pin_out,
    input wire logic [PINS-1:0] pin_oe
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    sequence wr_taken;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence resp_up;
        !s_axi_bvalid ##1 s_axi_bvalid;
    endsequence
    a_write_resp_time: assert property (wr_taken |=> resp_up)
        else $error("write response late or early");
    a_read_time: assert property (s_axi_arvalid && s_axi_arready |=>
        s_axi_rvalid) else $error("read data not one cycle after take");
    a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
        s_axi_rvalid && $stable(s_axi_rdata)) else $error("rdata dropped");
    a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
        s_axi_bvalid && $stable(s_axi_bresp)) else $error("bresp dropped");
    a_busy_refuse: assert property (s_axi_bvalid |->
        !s_axi_awready && !s_axi_wready) else $error("ready while busy");
    a_suspend_dflt: assert property (
        usb_suspend && ce |=> pin_oe == 4'he && pin_out == 4'h6)
        else $error("suspend defaults missing");
    a_oe_cause: assert property (
        $changed(pin_oe) |-> s_axi_bvalid || $past(usb_suspend) ||
        !$past(rst_n)) else $error("direction changed without cause");
    a_out_cause: assert property (
        $changed(pin_out) |-> s_axi_bvalid || $past(usb_suspend) ||
        !$past(rst_n)) else $error("drive level changed without cause");
endmodule
bind misc_pin_config_regs misc_pin_config_regs_monitor #(.PINS(PINS))
    misc_pin_config_regs_monitor_inst (.*);
`default_nettype wire

// >>> tb/misc_pin_config_regs_tb.sv
// self-checking bench for the general pin block
`timescale 1ns/1ns
`default_nettype none
module misc_pin_config_regs_tb;
    logic sys_clk, rst_n, ce, usb_suspend, irq;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
    logic s_axi_rvalid, s_axi_rready;
    logic [1:0] s_axi_bresp, s_axi_rresp, rs;
    logic [11:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, rd;
    logic [3:0] s_axi_wstrb, pin_in, pin_out, pin_oe, ext_lvl;
    int error_cnt, n_checks;
    localparam logic [11:0] C34 = {2'h0, misc_pin_pkg::IDX_CFG34, 2'h0};
    localparam logic [11:0] C56 = {2'h0, misc_pin_pkg::IDX_CFG56, 2'h0};
    localparam logic [11:0] STA = {2'h0, misc_pin_pkg::IDX_STATUS, 2'h0};
    localparam logic [11:0] IST = {2'h0, misc_pin_pkg::IDX_IRQ_STAT, 2'h0};
    localparam logic [11:0] MSK = {2'h0, misc_pin_pkg::IDX_IRQ_MASK, 2'h0};

    misc_pin_config_regs misc_pin_config_regs_inst (.*);
    pin_loads pin_loads_inst (.*);

    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end

    task automatic summarize;
        $display("checks %0d mismatches %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
        n_checks++;
        if (g !== e) begin
            error_cnt++;
            $display("[FAIL] %s exp %h got %h", nm, e, g);
        end
    endtask

    task automatic tmo(int n);
        if (n > 60) begin
            error_cnt++;
            $display("[FAIL] handshake exp done got timeout");
            summarize();
        end
    endtask

    // bready and rready stay high; each item dropped at its taking edge
    task automatic wr(logic [11:0] a, logic [31:0] d);
        logic got;
        got = 1'b0;
        s_axi_awaddr <= a;
        s_axi_awvalid <= 1'b1;
        s_axi_wdata <= d;
        s_axi_wvalid <= 1'b1;
        for (int n = 0; !got; n++) begin
            @(posedge sys_clk);
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
            got = s_axi_bvalid;
            rs = s_axi_bresp;
            tmo(n);
        end
    endtask

    task automatic rdx(logic [11:0] a);
        logic got;
        got = 1'b0;
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        for (int n = 0; !got; n++) begin
            @(posedge sys_clk);
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
            got = s_axi_rvalid;
            rd = s_axi_rdata;
            rs = s_axi_rresp;
            tmo(n);
        end
    endtask

    task automatic rck(string nm, logic [11:0] a, logic [31:0] e);
        rdx(a);
        chk(nm, e, rd);
        chk("rresp", 32'h0, 32'(rs));
    endtask

    task automatic cfg(logic [3:0] v);
        wr(C34, {24'h0, v, v});
        wr(C56, {24'h0, v, v});
        chk("bresp", 32'h0, 32'(rs));
    endtask

    task automatic t_defaults;
        chk("pin_oe", 32'he, 32'(pin_oe));
        chk("pin_out", 32'h6, 32'(pin_out));
        rck("cfg34", C34, 32'h90);
        rck("cfg56", C56, 32'h19);
        $display("test defaults done");
    endtask

    task automatic t_drive;
        for (int i = 0; i < 3; i++) begin
            cfg(i == 0 ? 4'h1 : i == 1 ? 4'h9 : 4'h0);
            chk("pin_oe", i < 2 ? 32'hf : 32'h0, 32'(pin_oe));
            chk("pin_out", i == 1 ? 32'hf : 32'h0, 32'(pin_out));
            rck("cfg56", C56, i == 1 ? 32'h99 : i == 0 ? 32'h11 : 32'h0);
        end
        $display("test drive done");
    endtask

    task automatic t_level;
        ext_lvl <= 4'h5;
        for (int i = 0; i < 2; i++) begin
            cfg(i ? 4'h2 : 4'h0);
            repeat (4) @(posedge sys_clk);
            rck("status", STA, i ? 32'h5 : 32'ha);
        end
        $display("test level done");
    endtask

    task automatic t_edge;
        ext_lvl <= 4'h0;
        cfg(4'h6);
        repeat (4) @(posedge sys_clk);
        rdx(STA);
        ext_lvl <= 4'hf;
        repeat (4) @(posedge sys_clk);
        ext_lvl <= 4'h0;
        repeat (4) @(posedge sys_clk);
        rck("status", STA, 32'hf);
        rck("status", STA, 32'h0);
        $display("test edge done");
    endtask

    task automatic t_irq;
        cfg(4'h2);
        repeat (4) @(posedge sys_clk);
        wr(IST, 32'hf);
        wr(MSK, 32'h1);
        chk("irq", 32'h0, 32'(irq));
        ext_lvl <= 4'h1;
        repeat (5) @(posedge sys_clk);
        chk("irq", 32'h1, 32'(irq));
        rck("irq_stat", IST, 32'h1);
        wr(MSK, 32'h0);
        chk("irq", 32'h0, 32'(irq));
        wr(MSK, 32'h1);
        chk("irq", 32'h1, 32'(irq));
        wr(IST, 32'h1);
        chk("irq", 32'h0, 32'(irq));
        rck("irq_stat", IST, 32'h0);
        $display("test irq done");
    endtask

    task automatic t_bad;
        wr(12'h3fc, 32'hff);
        chk("bresp", 32'h2, 32'(rs));
        rdx(12'h3fc);
        chk("rresp", 32'h2, 32'(rs));
        chk("rdata", 32'h0, rd);
        $display("test unmapped done");
    endtask

    task automatic t_suspend;
        cfg(4'h0);
        usb_suspend <= 1'b1;
        repeat (2) @(posedge sys_clk);
        chk("pin_oe", 32'he, 32'(pin_oe));
        chk("pin_out", 32'h6, 32'(pin_out));
        usb_suspend <= 1'b0;
        rck("cfg34", C34, 32'h90);
        $display("test suspend done");
    endtask

    initial begin
        {rst_n, usb_suspend, s_axi_awvalid, s_axi_wvalid} = 4'h0;
        {s_axi_bready, s_axi_arvalid, s_axi_rready} = 3'h5;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata, ext_lvl} = 60'h0;
        s_axi_wstrb = 4'hf;
        ce = 1'b1;
        error_cnt = 0;
        n_checks = 0;
        repeat (3) @(posedge sys_clk);
        rst_n <= 1'b1;
        @(posedge sys_clk);
        t_defaults();
        t_drive();
        t_level();
        t_edge();
        t_irq();
        t_bad();
        t_suspend();
        summarize();
    end
endmodule
`default_nettype wire

// >>> tb/pin_loads.sv
// switch and load model standing at the general pins
`timescale 1ns/1ns
`default_nettype none
module pin_loads #(
    parameter int PINS = 4
) (
    // pin side of the block
    input wire logic [PINS-1:0] pin_out,
    input wire logic [PINS-1:0] pin_oe,
    // switch levels set by the bench
    input wire logic [PINS-1:0] ext_lvl,
    output logic [PINS-1:0] pin_in
);
    // driven pin reads back its own level
    assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_lvl);
endmodule
`default_nettype wire
